// ### clk_ctrl_pkg.sv
// Constants and types shared by the oscillator and clock-gate controller
package clk_ctrl_pkg;

  // ----------------------------------------
  // Register port geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NREG   = 7;

  // Byte offsets of the registers
  localparam logic [7:0] OFS_FAST_OSC  = 8'h04;
  localparam logic [7:0] OFS_SLOW_OSC  = 8'h08;
  localparam logic [7:0] OFS_XTAL_OSC  = 8'h0c;
  localparam logic [7:0] OFS_SYS_GATE  = 8'h10;
  localparam logic [7:0] OFS_PER_GATE  = 8'h14;
  localparam logic [7:0] OFS_WORK_GATE = 8'h18;
  localparam logic [7:0] OFS_LP_GATE   = 8'h1c;

  // Register index, also the slot in the read word vector
  typedef enum logic [2:0]
  {
    IDX_FAST_OSC  = 3'h0,
    IDX_SLOW_OSC  = 3'h1,
    IDX_XTAL_OSC  = 3'h2,
    IDX_SYS_GATE  = 3'h3,
    IDX_PER_GATE  = 3'h4,
    IDX_WORK_GATE = 3'h5,
    IDX_LP_GATE   = 3'h6
  } reg_idx_t;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int unsigned FAST_EN_BIT   = 0;
  localparam int unsigned FAST_FREQ_LSB = 4;
  localparam int unsigned FAST_FREQ_W   = 2;
  localparam int unsigned SLOW_EN_BIT   = 0;
  localparam int unsigned XTAL_CORE_BIT = 0;
  localparam int unsigned XTAL_CLK_BIT  = 1;
  localparam int unsigned SYS_GATE_W    = 3;
  localparam int unsigned PER_GATE_W    = 16;
  localparam int unsigned RTC_WORK_BIT  = 0;
  localparam int unsigned LCD_WORK_BIT  = 1;

  // Fast oscillator frequency codes
  typedef enum logic [1:0]
  {
    FREQ_4MHZ  = 2'b00,
    FREQ_8MHZ  = 2'b01,
    FREQ_16MHZ = 2'b10,
    FREQ_32MHZ = 2'b11
  } fast_freq_t;

  // Power mode tracked from the power controller's events
  typedef enum logic [1:0]
  {
    PM_RUN   = 2'b00,
    PM_SLEEP = 2'b01,
    PM_STOP  = 2'b10
  } pm_state_t;

  // System clock selection forced on stop exit
  localparam logic [1:0] SYSTEM_CLOCK_SELECT_FAST = 2'h0;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam fast_freq_t  RST_FAST_FREQ = FREQ_8MHZ;
  localparam logic        RST_FAST_EN   = 1'h1;
  localparam logic        RST_SLOW_EN   = 1'h1;
  localparam logic        RST_XTAL      = 1'h0;
  localparam logic [2:0]  RST_SYS_GATE  = 3'h7;
  localparam logic [15:0] RST_PER_GATE  = 16'h0000;
  localparam logic        RST_WORK      = 1'h0;
  localparam logic [15:0] RST_LP_GATE   = 16'hffff;

  // Address match of one register
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

endpackage : clk_ctrl_pkg

// ### osc_and_clock_gate_ctrl.sv
// Oscillator enables and peripheral clock gating controller, top level
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module osc_and_clock_gate_ctrl
(
  input  wire logic                            mclk,                          // System clock, 50 MHz
  input  wire logic                            nrst,                          // Async reset, active low
  input  wire logic                            clk_en,                        // Freezes state when low
  input  wire logic [clk_ctrl_pkg::ADDR_W-1:0] reg_addr,                      // Register byte address
  input  wire logic [clk_ctrl_pkg::DATA_W-1:0] reg_wdata,                     // Register write data
  input  wire logic                            reg_wr,                        // Write strobe
  input  wire logic                            reg_rd,                        // Read strobe
  output var  logic [clk_ctrl_pkg::DATA_W-1:0] reg_rdata,                     // Read data
  input  wire logic                            sleep_entry,                   // Pulse: chip enters sleep
  input  wire logic                            stop_entry,                    // Pulse: chip enters stop
  input  wire logic                            wake_exit,                     // Pulse: chip leaves sleep/stop
  input  wire logic                            fast_osc_is_sysclk,            // Fast osc feeds system clock
  output var  logic [1:0]                      fast_osc_freq_sel,             // Fast osc frequency code
  output var  logic                            fast_osc_enable,               // Fast osc on
  output var  logic                            slow_internal_osc_enable,      // Slow internal osc on
  output var  logic                            slow_crystal_core_enable,      // Crystal core on
  output var  logic                            slow_crystal_clock_out_enable, // Crystal clock passed on
  output var  logic [2:0]                      system_bus_periph_gates,       // System bus clock gates
  output var  logic [15:0]                     periph_bus_gates,              // Peripheral bus clock gates
  output var  logic                            display_work_clock_enable,     // Display working clock
  output var  logic                            calendar_work_clock_enable,    // Calendar working clock
  output var  logic                            system_clock_select_force,     // Pulse: force selection
  output var  logic [1:0]                      system_clock_select_value,     // Forced selection code
  output var  logic                            low_power_active               // Sleep or stop in force
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    clk_ctrl_pkg::fast_freq_t freq;
    logic                     fast_en;
    logic                     slow_en;
    logic                     xtal_core;
    logic                     xtal_clk;
    logic [2:0]               sys_gate;
    logic [15:0]              per_gate;
    logic                     lcd_work;
    logic                     rtc_work;
    logic [15:0]              lp_gate;
    clk_ctrl_pkg::pm_state_t  pm;
    logic                     sel_force;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RESET = '{
    freq:      clk_ctrl_pkg::RST_FAST_FREQ,
    fast_en:   clk_ctrl_pkg::RST_FAST_EN,
    slow_en:   clk_ctrl_pkg::RST_SLOW_EN,
    xtal_core: clk_ctrl_pkg::RST_XTAL,
    xtal_clk:  clk_ctrl_pkg::RST_XTAL,
    sys_gate:  clk_ctrl_pkg::RST_SYS_GATE,
    per_gate:  clk_ctrl_pkg::RST_PER_GATE,
    lcd_work:  clk_ctrl_pkg::RST_WORK,
    rtc_work:  clk_ctrl_pkg::RST_WORK,
    lp_gate:   clk_ctrl_pkg::RST_LP_GATE,
    pm:        clk_ctrl_pkg::PM_RUN,
    sel_force: 1'h0
  };

  ctrl_state_t ctrl_reg;
  ctrl_state_t ctrl_next;
  logic        in_stop;
  logic        low_power;
  logic [1:0]  work_gate;

  reg_port_if rp ();

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  reg_port u_reg_port
  (
    .mclk      (mclk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .rp        (rp)
  );

  assign in_stop   = (ctrl_reg.pm == clk_ctrl_pkg::PM_STOP);
  assign low_power = (ctrl_reg.pm != clk_ctrl_pkg::PM_RUN);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    ctrl_next           = ctrl_reg;
    ctrl_next.sel_force = 1'h0;

    // Power mode tracking; wake wins over a late entry event
    case (ctrl_reg.pm)
      clk_ctrl_pkg::PM_RUN:
      begin
        if (stop_entry)
          ctrl_next.pm = clk_ctrl_pkg::PM_STOP;
        else if (sleep_entry)
          ctrl_next.pm = clk_ctrl_pkg::PM_SLEEP;
      end
      clk_ctrl_pkg::PM_SLEEP:
      begin
        if (wake_exit)
          ctrl_next.pm = clk_ctrl_pkg::PM_RUN;
        else if (stop_entry)
          ctrl_next.pm = clk_ctrl_pkg::PM_STOP;
      end
      clk_ctrl_pkg::PM_STOP:
      begin
        if (wake_exit)
          ctrl_next.pm = clk_ctrl_pkg::PM_RUN;
      end
      default:
      begin
        ctrl_next.pm = clk_ctrl_pkg::PM_RUN;
      end
    endcase

    // Fast oscillator register: frequency and enable
    if (rp.wr_hit[clk_ctrl_pkg::IDX_FAST_OSC])
    begin
      ctrl_next.freq = clk_ctrl_pkg::fast_freq_t'(
        rp.wdata[clk_ctrl_pkg::FAST_FREQ_LSB +: clk_ctrl_pkg::FAST_FREQ_W]);
      ctrl_next.fast_en = rp.wdata[clk_ctrl_pkg::FAST_EN_BIT];
    end

    // clear refused while the oscillator clocks the system
    if (fast_osc_is_sysclk && !in_stop)
    begin
      ctrl_next.fast_en = 1'h1;
    end

    // stop entry stops the fast oscillator
    if ((ctrl_next.pm == clk_ctrl_pkg::PM_STOP) && (ctrl_reg.pm != clk_ctrl_pkg::PM_STOP))
    begin
      ctrl_next.fast_en = 1'h0;
    end

    // stop exit restarts fast osc and forces the selection
    if (wake_exit && in_stop)
    begin
      // on again for the forced system clock
      ctrl_next.fast_en   = 1'h1;
      ctrl_next.sel_force = 1'h1;
    end

    if (rp.wr_hit[clk_ctrl_pkg::IDX_SLOW_OSC])
    begin
      ctrl_next.slow_en = rp.wdata[clk_ctrl_pkg::SLOW_EN_BIT];
    end

    // Crystal oscillator; sequencing is left to software
    if (rp.wr_hit[clk_ctrl_pkg::IDX_XTAL_OSC])
    begin
      ctrl_next.xtal_core = rp.wdata[clk_ctrl_pkg::XTAL_CORE_BIT];
      ctrl_next.xtal_clk  = rp.wdata[clk_ctrl_pkg::XTAL_CLK_BIT];
    end

    if (rp.wr_hit[clk_ctrl_pkg::IDX_SYS_GATE])
    begin
      ctrl_next.sys_gate = rp.wdata[clk_ctrl_pkg::SYS_GATE_W-1:0];
    end

    if (rp.wr_hit[clk_ctrl_pkg::IDX_PER_GATE])
    begin
      ctrl_next.per_gate = rp.wdata[clk_ctrl_pkg::PER_GATE_W-1:0];
    end

    if (rp.wr_hit[clk_ctrl_pkg::IDX_WORK_GATE])
    begin
      ctrl_next.lcd_work = rp.wdata[clk_ctrl_pkg::LCD_WORK_BIT];
      ctrl_next.rtc_work = rp.wdata[clk_ctrl_pkg::RTC_WORK_BIT];
    end

    if (rp.wr_hit[clk_ctrl_pkg::IDX_LP_GATE])
    begin
      ctrl_next.lp_gate = rp.wdata[clk_ctrl_pkg::PER_GATE_W-1:0];
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ctrl_reg <= CTRL_RESET;
    else if (clk_en)
      ctrl_reg <= ctrl_next;
  end

  // ----------------------------------------
  // Read words
  // ----------------------------------------
  // reserved bits read zero
  always_comb
  begin
    rp.rd_words = '0;
    rp.rd_words[clk_ctrl_pkg::IDX_FAST_OSC][clk_ctrl_pkg::FAST_FREQ_LSB +: clk_ctrl_pkg::FAST_FREQ_W] =
      ctrl_reg.freq;
    rp.rd_words[clk_ctrl_pkg::IDX_FAST_OSC][clk_ctrl_pkg::FAST_EN_BIT]   = ctrl_reg.fast_en;
    rp.rd_words[clk_ctrl_pkg::IDX_SLOW_OSC][clk_ctrl_pkg::SLOW_EN_BIT]   = ctrl_reg.slow_en;
    rp.rd_words[clk_ctrl_pkg::IDX_XTAL_OSC][clk_ctrl_pkg::XTAL_CORE_BIT] = ctrl_reg.xtal_core;
    rp.rd_words[clk_ctrl_pkg::IDX_XTAL_OSC][clk_ctrl_pkg::XTAL_CLK_BIT]  = ctrl_reg.xtal_clk;
    rp.rd_words[clk_ctrl_pkg::IDX_SYS_GATE][clk_ctrl_pkg::SYS_GATE_W-1:0] = ctrl_reg.sys_gate;
    rp.rd_words[clk_ctrl_pkg::IDX_PER_GATE][clk_ctrl_pkg::PER_GATE_W-1:0] = ctrl_reg.per_gate;
    rp.rd_words[clk_ctrl_pkg::IDX_WORK_GATE][clk_ctrl_pkg::LCD_WORK_BIT]  = ctrl_reg.lcd_work;
    rp.rd_words[clk_ctrl_pkg::IDX_WORK_GATE][clk_ctrl_pkg::RTC_WORK_BIT]  = ctrl_reg.rtc_work;
    rp.rd_words[clk_ctrl_pkg::IDX_LP_GATE][clk_ctrl_pkg::PER_GATE_W-1:0]  = ctrl_reg.lp_gate;
  end

  // ----------------------------------------
  // Clock gates
  // ----------------------------------------
  // masked gating in sleep and stop
  periph_gate
  #(
    .APB_W (clk_ctrl_pkg::PER_GATE_W),
    .AHB_W (clk_ctrl_pkg::SYS_GATE_W)
  )
  u_periph_gate
  (
    .mclk      (mclk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .low_power (low_power),
    .apb_run   (ctrl_reg.per_gate),
    .apb_lp    (ctrl_reg.lp_gate),
    .ahb_run   (ctrl_reg.sys_gate),
    .work_run  ({ctrl_reg.lcd_work, ctrl_reg.rtc_work}),
    .apb_gate  (periph_bus_gates),
    .ahb_gate  (system_bus_periph_gates),
    .work_gate (work_gate)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Oscillator controls straight from the state register
  assign fast_osc_freq_sel             = ctrl_reg.freq;
  assign fast_osc_enable               = ctrl_reg.fast_en;
  assign slow_internal_osc_enable      = ctrl_reg.slow_en;
  assign slow_crystal_core_enable      = ctrl_reg.xtal_core;
  // crystal clock onward only with its output enable
  assign slow_crystal_clock_out_enable = ctrl_reg.xtal_clk;

  // Working clock gates from the gate stage
  assign display_work_clock_enable  = work_gate[1];
  assign calendar_work_clock_enable = work_gate[0];

  // forced selection towards the clock switch
  assign system_clock_select_force = ctrl_reg.sel_force;
  assign system_clock_select_value = clk_ctrl_pkg::SYSTEM_CLOCK_SELECT_FAST;
  assign low_power_active          = low_power;

endmodule : osc_and_clock_gate_ctrl
`default_nettype wire

// ### osc_and_clock_gate_ctrl_checker.sv
// Concurrent checks on the clock controller ports
`timescale 1ns/10ps
`default_nettype none
module osc_and_clock_gate_ctrl_checker
(
  input wire logic        mclk,                      // Clock
  input wire logic        nrst,                      // Reset
  input wire logic        clk_en,                    // Enable
  input wire logic [7:0]  reg_addr,                  // Address
  input wire logic [31:0] reg_wdata,                 // Write data
  input wire logic        reg_wr,                    // Write
  input wire logic        reg_rd,                    // Read
  input wire logic [31:0] reg_rdata,                 // Read data
  input wire logic        stop_entry,                // Stop event
  input wire logic        wake_exit,                 // Wake event
  input wire logic        fast_osc_is_sysclk,        // Keep request
  input wire logic [1:0]  fast_osc_freq_sel,         // Frequency
  input wire logic        fast_osc_enable,           // Fast osc on
  input wire logic [2:0]  system_bus_periph_gates,   // Bus gates
  input wire logic        system_clock_select_force, // Force pulse
  input wire logic [1:0]  system_clock_select_value, // Forced code
  input wire logic        low_power_active           // Low power
);
  // ----------------------------------------
  // Stop mode tracking
  // ----------------------------------------
  logic in_stop_reg;

  // Follows stop entry and wake events
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      in_stop_reg <= 1'b0;
    else if (clk_en && wake_exit && low_power_active)
      in_stop_reg <= 1'b0;
    else if (clk_en && stop_entry)
      in_stop_reg <= 1'b1;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_stop_clears_fast: assert property (clk_en && stop_entry && !low_power_active |=>
    !fast_osc_enable && low_power_active) else $error("fast osc on after stop entry");
  a_stop_exit_force: assert property (clk_en && wake_exit && in_stop_reg |=>
    fast_osc_enable && system_clock_select_force ##1 !system_clock_select_force) else $error("bad stop exit");
  a_keep_fast_on: assert property (clk_en && fast_osc_is_sysclk && !stop_entry && !in_stop_reg |=>
    fast_osc_enable) else $error("fast osc dropped while feeding system clock");
  a_force_code_zero: assert property (system_clock_select_force |->
    system_clock_select_value == 2'h0) else $error("forced selection not zero");
  a_force_cause: assert property (system_clock_select_force |->
    $past(wake_exit) && $past(in_stop_reg) && $past(clk_en)) else $error("force without stop exit");
  a_rdata_idle_zero: assert property ($past(clk_en) && !$past(reg_rd) |->
    reg_rdata == 32'h0) else $error("read data not zero when idle");
  a_sys_gate_follow: assert property (clk_en && reg_wr && reg_addr == 8'h10 ##1 clk_en |=>
    {29'h0, system_bus_periph_gates} == ($past(reg_wdata, 2) & 32'h7)) else $error("bus gates wrong");
  a_freq_write: assert property (clk_en && reg_wr && reg_addr == 8'h04 |=>
    {30'h0, fast_osc_freq_sel} == (($past(reg_wdata) >> 4) & 32'h3)) else $error("frequency wrong");
  a_frozen_state: assert property (!clk_en |=>
    $stable(fast_osc_freq_sel) && $stable(system_bus_periph_gates)) else $error("state moved while frozen");

  // Main scenarios reached
  c_stop_exit: cover property (system_clock_select_force);
  c_keep_write: cover property (fast_osc_is_sysclk && reg_wr && reg_addr == 8'h04);
  c_low_power: cover property ($rose(low_power_active));
endmodule : osc_and_clock_gate_ctrl_checker
`default_nettype wire

// ### osc_and_clock_gate_ctrl_tb.sv
// Self-checking testbench of the oscillator and clock-gate controller
`timescale 1ns/10ps
`default_nettype none
module osc_and_clock_gate_ctrl_tb;
  // ----------------------------------------
  // Signals and expected state
  // ----------------------------------------
  logic        mclk, nrst, clk_en, reg_wr, reg_rd, lp;
  logic        sleep_entry, stop_entry, wake_exit, fast_osc_is_sysclk;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0]  fast_osc_freq_sel, system_clock_select_value;
  logic [2:0]  system_bus_periph_gates;
  logic [15:0] periph_bus_gates;
  logic        fast_osc_enable, slow_internal_osc_enable, slow_crystal_core_enable;
  logic        slow_crystal_clock_out_enable, display_work_clock_enable, calendar_work_clock_enable;
  logic        system_clock_select_force, low_power_active;
  logic [31:0] sh [7];
  logic [7:0]  adr [9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h00, 8'h20};
  logic [31:0] msk [9] = '{32'h31, 32'h1, 32'h3, 32'h7, 32'hffff, 32'h3, 32'hffff, 32'h0, 32'h0};
  logic [31:0] rv  [9] = '{32'h11, 32'h1, 32'h0, 32'h7, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h0};
  int          n_errors, checks, cyc, seed, i, k;

  osc_and_clock_gate_ctrl osc_and_clock_gate_ctrl_inst
  (
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_entry(sleep_entry),
    .stop_entry(stop_entry), .wake_exit(wake_exit), .fast_osc_is_sysclk(fast_osc_is_sysclk),
    .fast_osc_freq_sel(fast_osc_freq_sel), .fast_osc_enable(fast_osc_enable),
    .slow_internal_osc_enable(slow_internal_osc_enable), .slow_crystal_core_enable(slow_crystal_core_enable),
    .slow_crystal_clock_out_enable(slow_crystal_clock_out_enable),
    .system_bus_periph_gates(system_bus_periph_gates), .periph_bus_gates(periph_bus_gates),
    .display_work_clock_enable(display_work_clock_enable),
    .calendar_work_clock_enable(calendar_work_clock_enable),
    .system_clock_select_force(system_clock_select_force),
    .system_clock_select_value(system_clock_select_value), .low_power_active(low_power_active)
  );

  // Clock of 20 ns and cycle ceiling
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Write cycle, expected state follows it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    for (int j = 0; j < 7; j++)
      if (clk_en && a == adr[j])
        sh[j] = d & msk[j];
    if (clk_en && a == 8'h04 && fast_osc_is_sysclk)
      sh[0][0] = 1'b1;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
    @(posedge mclk);
  endtask : rd

  // One power event pulse: 0 sleep, 1 stop, 2 wake
  task automatic ev(input int w);
    {sleep_entry, stop_entry, wake_exit} <= 3'b100 >> w;
    @(posedge mclk);
    {sleep_entry, stop_entry, wake_exit} <= 3'b000;
    #1;
  endtask : ev

  task automatic outs;
    #1;
    chk("freq_sel", sh[0][5:4], fast_osc_freq_sel);
    chk("fast_en", sh[0][0], fast_osc_enable);
    chk("slow_en", sh[1][0], slow_internal_osc_enable);
    chk("xtal_core", sh[2][0], slow_crystal_core_enable);
    chk("xtal_out", sh[2][1], slow_crystal_clock_out_enable);
    chk("sys_gates", sh[3], system_bus_periph_gates);
    chk("per_gates", lp ? sh[4] & sh[6] : sh[4], periph_bus_gates);
    chk("lcd_work", sh[5][1], display_work_clock_enable);
    chk("rtc_work", sh[5][0], calendar_work_clock_enable);
    chk("low_power", lp, low_power_active);
    @(posedge mclk);
  endtask : outs

  // Reset, then reset values at the outputs and in every register
  task automatic rst_chk;
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    lp = 1'b0;
    for (k = 0; k < 7; k++)
      sh[k] = rv[k];
    @(posedge mclk);
    outs();
    for (k = 0; k < 9; k++)
      rd(adr[k], rv[k]);
  endtask : rst_chk

  task automatic test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'hb2958cb2;
    {nrst, reg_wr, reg_rd, sleep_entry, stop_entry, wake_exit, fast_osc_is_sysclk} = 7'h0;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    @(posedge mclk);
    rst_chk();
    // Random writes, the unmapped places among them
    for (i = 0; i < 40; i++)
    begin
      k = {$random(seed)} % 9;
      wr(adr[k], $random(seed));
      outs();
      rd(adr[k], k < 7 ? sh[k] : 32'h0);
    end
    for (i = 0; i < 4; i++)
    begin
      wr(8'h04, {26'h0, i[1:0], 4'h1});
      outs();
    end
    // Software clear refused while feeding the system clock
    fast_osc_is_sysclk <= 1'b1;
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h1);
    wr(8'h14, 32'ha5c3);
    wr(8'h1c, 32'h0ff0);
    // Stop beats the keep request, wake restores and forces selection
    ev(1);
    chk("fast_en", 32'h0, fast_osc_enable);
    sh[0][0] = 1'b0;
    lp = 1'b1;
    @(posedge mclk);
    outs();
    ev(2);
    chk("force", 32'h1, system_clock_select_force);
    chk("force_val", 32'h0, system_clock_select_value);
    chk("fast_en", 32'h1, fast_osc_enable);
    sh[0][0] = 1'b1;
    lp = 1'b0;
    @(posedge mclk);
    #1;
    chk("force", 32'h0, system_clock_select_force);
    outs();
    // Sleep keeps the oscillator, then stop from sleep
    fast_osc_is_sysclk <= 1'b0;
    ev(0);
    lp = 1'b1;
    @(posedge mclk);
    outs();
    ev(1);
    sh[0][0] = 1'b0;
    @(posedge mclk);
    outs();
    ev(2);
    sh[0][0] = 1'b1;
    lp = 1'b0;
    @(posedge mclk);
    outs();
    // crystal core and clock output on together
    wr(8'h0c, 32'h3);
    // Frozen write is lost
    clk_en <= 1'b0;
    wr(8'h18, 32'h3);
    clk_en <= 1'b1;
    outs();
    rst_chk();
    test_done();
  end
endmodule : osc_and_clock_gate_ctrl_tb

bind osc_and_clock_gate_ctrl osc_and_clock_gate_ctrl_checker osc_and_clock_gate_ctrl_checker_inst
(
  .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_entry(stop_entry),
  .wake_exit(wake_exit), .fast_osc_is_sysclk(fast_osc_is_sysclk), .fast_osc_freq_sel(fast_osc_freq_sel),
  .fast_osc_enable(fast_osc_enable), .system_bus_periph_gates(system_bus_periph_gates),
  .system_clock_select_force(system_clock_select_force),
  .system_clock_select_value(system_clock_select_value), .low_power_active(low_power_active)
);
`default_nettype wire

// ### periph_gate.sv
// Per power mode combination of bus and working clock gates
`timescale 1ns/10ps
`default_nettype none
module periph_gate
#(
  parameter int unsigned APB_W = 16, // Peripheral bus gate count
  parameter int unsigned AHB_W = 3   // System bus gate count
)
(
  input  wire logic             mclk,       // System clock
  input  wire logic             nrst,       // Async reset, active low
  input  wire logic             clk_en,     // Freezes state when low
  input  wire logic             low_power,  // Sleep or stop active
  input  wire logic [APB_W-1:0] apb_run,    // Run mode gates
  input  wire logic [APB_W-1:0] apb_lp,     // Low power keep-running mask
  input  wire logic [AHB_W-1:0] ahb_run,    // System bus gates
  input  wire logic [1:0]       work_run,   // Working clock gates
  output var  logic [APB_W-1:0] apb_gate,   // Effective peripheral bus gates
  output var  logic [AHB_W-1:0] ahb_gate,   // Effective system bus gates
  output var  logic [1:0]       work_gate   // Effective working clock gates
);

  typedef struct packed
  {
    logic [APB_W-1:0] apb;
    logic [AHB_W-1:0] ahb;
    logic [1:0]       work;
  } gate_state_t;

  gate_state_t gate_reg;
  gate_state_t gate_next;

  // In sleep or stop only masked peripheral bus clocks keep running; system bus and working gates pass unmasked
  always_comb
  begin
    gate_next      = gate_reg;
    gate_next.apb  = low_power ? (apb_run & apb_lp) : apb_run;
    gate_next.ahb  = ahb_run;
    gate_next.work = work_run;
  end

  // State register, all gates closed in reset
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      gate_reg <= '0;
    else if (clk_en)
      gate_reg <= gate_next;
  end

  assign apb_gate  = gate_reg.apb;
  assign ahb_gate  = gate_reg.ahb;
  assign work_gate = gate_reg.work;

endmodule : periph_gate
`default_nettype wire

// ### reg_port.sv
// Register port address decode and registered read data
`timescale 1ns/10ps
`default_nettype none
module reg_port
(
  input  wire logic                              mclk,      // System clock
  input  wire logic                              nrst,      // Async reset, active low
  input  wire logic                              clk_en,    // Freezes state when low
  input  wire logic [clk_ctrl_pkg::ADDR_W-1:0]   reg_addr,  // Byte address
  input  wire logic [clk_ctrl_pkg::DATA_W-1:0]   reg_wdata, // Write data
  input  wire logic                              reg_wr,    // Write strobe
  input  wire logic                              reg_rd,    // Read strobe
  output var  logic [clk_ctrl_pkg::DATA_W-1:0]   reg_rdata, // Read data, cycle after strobe
  reg_port_if.decoder                            rp         // Decoded strobes
);

  typedef struct packed
  {
    logic [clk_ctrl_pkg::DATA_W-1:0] rdata;
  } port_state_t;

  localparam logic [clk_ctrl_pkg::ADDR_W-1:0] OFS [clk_ctrl_pkg::NREG] = '{
    clk_ctrl_pkg::OFS_FAST_OSC, clk_ctrl_pkg::OFS_SLOW_OSC, clk_ctrl_pkg::OFS_XTAL_OSC,
    clk_ctrl_pkg::OFS_SYS_GATE, clk_ctrl_pkg::OFS_PER_GATE, clk_ctrl_pkg::OFS_WORK_GATE,
    clk_ctrl_pkg::OFS_LP_GATE};

  port_state_t port_reg;
  port_state_t port_next;

  // Write strobe per register; unmapped writes hit nothing
  always_comb
  begin
    rp.wdata = reg_wdata;
    for (int i = 0; i < clk_ctrl_pkg::NREG; i++)
    begin
      rp.wr_hit[i] = reg_wr & clk_en & clk_ctrl_pkg::reg_hit(reg_addr, OFS[i]);
    end
  end

  // Read mux; unmapped and idle cycles read zero
  always_comb
  begin
    port_next.rdata = '0;
    for (int i = 0; i < clk_ctrl_pkg::NREG; i++)
    begin
      if (reg_rd && clk_ctrl_pkg::reg_hit(reg_addr, OFS[i]))
      begin
        port_next.rdata = rp.rd_words[i];
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      port_reg <= '0;
    else if (clk_en)
      port_reg <= port_next;
  end

  assign reg_rdata = port_reg.rdata;

endmodule : reg_port
`default_nettype wire

// ### reg_port_if.sv
// Decoded register strobes and read words between decoder and register owner
`timescale 1ns/10ps
`default_nettype none
interface reg_port_if;
  logic [clk_ctrl_pkg::NREG-1:0]                           wr_hit;
  logic [clk_ctrl_pkg::DATA_W-1:0]                         wdata;
  logic [clk_ctrl_pkg::NREG-1:0][clk_ctrl_pkg::DATA_W-1:0] rd_words;

  // Decoder drives strobes, reads back words
  modport decoder (output wr_hit, output wdata, input rd_words);
  // Owner takes strobes, presents words
  modport owner (input wr_hit, input wdata, output rd_words);
endinterface : reg_port_if
`default_nettype wire
